// file: core/ldr_pkg.sv
// constants shared by the lighting director register bank
`default_nettype none
package ldr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned IDX_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DIRECTOR_CONFIG  = 10'h060;
  localparam logic [IDX_W-1:0] IDX_DIRECTOR_CONTROL = 10'h061;
  localparam logic [IDX_W-1:0] IDX_CH1_HIGH         = 10'h062;
  localparam logic [IDX_W-1:0] IDX_CH1_LOW          = 10'h063;
  localparam logic [IDX_W-1:0] IDX_CH2_HIGH         = 10'h064;
  localparam logic [IDX_W-1:0] IDX_CH2_LOW          = 10'h065;
  localparam logic [IDX_W-1:0] IDX_CH3_HIGH         = 10'h066;
  localparam logic [IDX_W-1:0] IDX_CH3_LOW          = 10'h067;
  localparam logic [IDX_W-1:0] IDX_LUX_HIGH         = 10'h070;
  localparam logic [IDX_W-1:0] IDX_LUX_LOW          = 10'h071;
  localparam logic [IDX_W-1:0] IDX_CCT_HIGH         = 10'h072;
  localparam logic [IDX_W-1:0] IDX_CCT_LOW          = 10'h073;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 10'h080;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK         = 10'h081;

  // director_config fields
  localparam int unsigned CFG_MODE_LSB = 4;
  localparam int unsigned CFG_MODE_MSB = 7;
  localparam int unsigned CFG_INT_BIT  = 1;
  localparam int unsigned CFG_LEARN_BIT = 0;
  // director_control fields
  localparam int unsigned CTL_START_BIT = 0;
  // interrupt status / mask fields
  localparam int unsigned IRQ_RESULT_BIT = 0;
  localparam int unsigned IRQ_LEARN_BIT  = 1;
  localparam int unsigned IRQ_W          = 2;

  typedef logic [3:0] ldr_mode_t;
  localparam ldr_mode_t MODE_DAYLIGHT      = 4'h0;
  localparam ldr_mode_t MODE_DAY_PLUS_TUNE = 4'h1;
  localparam ldr_mode_t MODE_COMBINED      = 4'h2;

  localparam logic [BYTE_W-1:0] CFG_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] CTL_RESET  = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;

endpackage
`default_nettype wire

// file: core/ldr_regs.sv
// APB register bank of the lighting director
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module ldr_regs
  import ldr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              core_result_valid,
  input  wire logic [WORD_W-1:0] core_level,
  input  wire logic [WORD_W-1:0] core_tune_a,
  input  wire logic [WORD_W-1:0] core_tune_b,
  input  wire logic              core_learn_done,
  output var  logic              conv_start,
  output var  logic              learn_active,
  output var  logic [3:0]        channel_configuration,
  output var  logic [WORD_W-1:0] lux_target,
  output var  logic [WORD_W-1:0] cct_target,
  output var  logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    idx_mapped = (idx >= IDX_DIRECTOR_CONFIG && idx <= IDX_CH3_LOW) ||
                 (idx >= IDX_LUX_HIGH && idx <= IDX_CCT_LOW) ||
                 idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
  endfunction

  logic              pready_ff;
  logic              pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [BYTE_W-1:0] cfg_ff;
  logic              start_ff;
  logic [WORD_W-1:0] ch1_ff;
  logic [WORD_W-1:0] ch2_ff;
  logic [WORD_W-1:0] ch3_ff;
  logic [WORD_W-1:0] lux_ff;
  logic [WORD_W-1:0] cct_ff;
  logic [IRQ_W-1:0]  status_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic              irq_ff;

  wire logic [IDX_W-1:0]  idx       = paddr[ADDR_W-1:2];
  wire logic              aligned   = (paddr[1:0] == 2'h0);
  wire logic              hit       = aligned && idx_mapped(idx);
  wire logic              setup     = psel && !penable;
  wire logic              wr_en     = psel && penable && pwrite && pready_ff && hit;
  wire logic [BYTE_W-1:0] wbyte     = pwdata[BYTE_W-1:0];
  wire logic              wr_cfg    = wr_en && idx == IDX_DIRECTOR_CONFIG;
  wire logic              wr_ctl    = wr_en && idx == IDX_DIRECTOR_CONTROL;
  wire logic              wr_lux_h  = wr_en && idx == IDX_LUX_HIGH;
  wire logic              wr_lux_l  = wr_en && idx == IDX_LUX_LOW;
  wire logic              wr_cct_h  = wr_en && idx == IDX_CCT_HIGH;
  wire logic              wr_cct_l  = wr_en && idx == IDX_CCT_LOW;
  wire logic              wr_status = wr_en && idx == IDX_IRQ_STATUS;
  wire logic              wr_mask   = wr_en && idx == IDX_IRQ_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // result mapping per channel configuration

  wire ldr_mode_t mode = cfg_ff[CFG_MODE_MSB:CFG_MODE_LSB];

  // core_level is dimming in configs 0/1 and brightness in config 2
  wire logic [WORD_W-1:0] nxt_ch1 = core_level;
  wire logic [WORD_W-1:0] nxt_ch2 =
    (mode == MODE_DAY_PLUS_TUNE) ? core_tune_a :
    (mode == MODE_COMBINED)      ? core_tune_b : WORD_RESET;
  wire logic [WORD_W-1:0] nxt_ch3 =
    (mode == MODE_DAY_PLUS_TUNE) ? ~core_tune_a :
    (mode == MODE_COMBINED)      ? core_tune_b : WORD_RESET;

  // a result only counts while a conversion is pending
  wire logic result_evt = core_result_valid && start_ff;
  wire logic learn_evt  = core_learn_done && cfg_ff[CFG_LEARN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next-state values

  logic [BYTE_W-1:0] nxt_cfg;
  always_comb begin
    nxt_cfg = cfg_ff;
    if (learn_evt) begin
      nxt_cfg[CFG_LEARN_BIT] = 1'b0;
    end
    if (wr_cfg) begin
      nxt_cfg = {wbyte[CFG_MODE_MSB:CFG_MODE_LSB], 2'h0,
                 wbyte[CFG_INT_BIT], wbyte[CFG_LEARN_BIT] | nxt_cfg[CFG_LEARN_BIT]};
    end
  end

  // a host write of one in the completion cycle keeps the new request
  wire logic nxt_start = wr_ctl ? wbyte[CTL_START_BIT] :
                         (result_evt ? 1'b0 : start_ff);

  wire logic [IRQ_W-1:0] evt_vec = {learn_evt, result_evt};
  // set wins over write-one-to-clear
  wire logic [IRQ_W-1:0] nxt_status =
    (status_ff & ~(wr_status ? wbyte[IRQ_W-1:0] : IRQ_RESET)) | evt_vec;
  wire logic nxt_irq = nxt_cfg[CFG_INT_BIT] && |(nxt_status & mask_ff);

  wire logic [WORD_W-1:0] nxt_lux = {wr_lux_h ? wbyte : lux_ff[WORD_W-1:BYTE_W],
                                     wr_lux_l ? wbyte : lux_ff[BYTE_W-1:0]};
  wire logic [WORD_W-1:0] nxt_cct = {wr_cct_h ? wbyte : cct_ff[WORD_W-1:BYTE_W],
                                     wr_cct_l ? wbyte : cct_ff[BYTE_W-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // read selection, high byte at the lower index

  wire logic [BYTE_W-1:0] rd_byte =
    (idx == IDX_DIRECTOR_CONFIG)  ? cfg_ff :
    (idx == IDX_DIRECTOR_CONTROL) ? {7'h00, start_ff} :
    (idx == IDX_CH1_HIGH)         ? ch1_ff[WORD_W-1:BYTE_W] :
    (idx == IDX_CH1_LOW)          ? ch1_ff[BYTE_W-1:0] :
    (idx == IDX_CH2_HIGH)         ? ch2_ff[WORD_W-1:BYTE_W] :
    (idx == IDX_CH2_LOW)          ? ch2_ff[BYTE_W-1:0] :
    (idx == IDX_CH3_HIGH)         ? ch3_ff[WORD_W-1:BYTE_W] :
    (idx == IDX_CH3_LOW)          ? ch3_ff[BYTE_W-1:0] :
    (idx == IDX_LUX_HIGH)         ? lux_ff[WORD_W-1:BYTE_W] :
    (idx == IDX_LUX_LOW)          ? lux_ff[BYTE_W-1:0] :
    (idx == IDX_CCT_HIGH)         ? cct_ff[WORD_W-1:BYTE_W] :
    (idx == IDX_CCT_LOW)          ? cct_ff[BYTE_W-1:0] :
    (idx == IDX_IRQ_STATUS)       ? {6'h00, status_ff} :
    (idx == IDX_IRQ_MASK)         ? {6'h00, mask_ff} : 8'h00;

  wire logic [DATA_W-1:0] nxt_prdata = (setup && !pwrite && hit) ?
                                       {24'h000000, rd_byte} : {DATA_W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: no wait state, data captured in the setup cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= {DATA_W{1'b0}};
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !hit;
      prdata_ff  <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and target registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff   <= CFG_RESET;
      start_ff <= 1'b0;
      lux_ff   <= WORD_RESET;
      cct_ff   <= WORD_RESET;
    end else begin
      cfg_ff   <= nxt_cfg;
      start_ff <= nxt_start;
      lux_ff   <= nxt_lux;
      cct_ff   <= nxt_cct;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result words, loaded when a core result arrives while the start bit is set

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_ff <= WORD_RESET;
      ch2_ff <= WORD_RESET;
      ch3_ff <= WORD_RESET;
    end else if (result_evt) begin
      ch1_ff <= nxt_ch1;
      ch2_ff <= nxt_ch2;
      ch3_ff <= nxt_ch3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and pin

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= IRQ_RESET;
      mask_ff   <= IRQ_RESET;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= wr_mask ? wbyte[IRQ_W-1:0] : mask_ff;
      irq_ff    <= nxt_irq;
    end
  end

  assign prdata                = prdata_ff;
  assign pready                = pready_ff;
  assign pslverr               = pslverr_ff;
  assign conv_start            = start_ff;
  assign learn_active          = cfg_ff[CFG_LEARN_BIT];
  assign channel_configuration = cfg_ff[CFG_MODE_MSB:CFG_MODE_LSB];
  assign lux_target            = lux_ff;
  assign cct_target            = cct_ff;
  assign irq                   = irq_ff;

endmodule

`default_nettype wire

// file: tb/ldr_regs_properties.sv
// checker of the lighting director register bank
`timescale 1ns/10ps
`default_nettype none
module ldr_regs_properties
  import ldr_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              core_result_valid,
  input wire logic              core_learn_done,
  input wire logic              conv_start,
  input wire logic              learn_active,
  input wire logic [3:0]        channel_configuration,
  input wire logic [WORD_W-1:0] lux_target,
  input wire logic              irq
);
  wire logic acc = psel && penable && pready && pwrite;
  wire logic cfg = paddr == {IDX_DIRECTOR_CONFIG, 2'h0};
  wire logic ctl = paddr == {IDX_DIRECTOR_CONTROL, 2'h0};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> penable && pready)
    else $error("no ready after setup");
  misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  mode_write_a: assert property (acc && cfg |=>
    channel_configuration == $past(pwdata[7:4])) else $error("mode not taken");
  lux_high_a: assert property (acc && paddr == {IDX_LUX_HIGH, 2'h0} |=>
    lux_target[15:8] == $past(pwdata[7:0])) else $error("lux high byte wrong");
  start_clear_a: assert property (conv_start && core_result_valid && !(acc && ctl)
    |=> !conv_start) else $error("start bit not cleared");
  learn_clear_a: assert property (learn_active && core_learn_done && !(acc && cfg)
    |=> !learn_active) else $error("learn bit not cleared");
  irq_cause_a: assert property ($rose(irq) |->
    $past(core_result_valid || core_learn_done || acc)) else $error("irq without cause");
endmodule
`default_nettype wire

// file: tb/ldr_core_model.sv
// director core stand-in answering start and learn requests
`timescale 1ns/10ps
`default_nettype none
module ldr_core_model
  import ldr_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              conv_start,
  input wire logic              learn_active,
  input wire logic [2:0]        dly,
  input wire logic [WORD_W-1:0] lvl,
  input wire logic [WORD_W-1:0] ta,
  input wire logic [WORD_W-1:0] tb_v,
  output var logic              res_ff,
  output var logic              learn_ff,
  output logic     [WORD_W-1:0] core_level,
  output logic     [WORD_W-1:0] core_tune_a,
  output logic     [WORD_W-1:0] core_tune_b
);
  logic [2:0] cnt_ff;
  wire logic busy = conv_start || learn_active;
  wire logic hit = busy && cnt_ff == dly;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'h0;
      res_ff <= 1'b0;
      learn_ff <= 1'b0;
    end else begin
      cnt_ff <= (hit || !busy) ? 3'h0 : cnt_ff + 3'h1;
      res_ff <= hit && conv_start;
      learn_ff <= hit && learn_active;
    end
  end
  // words are scrambled outside the pulse so stale sampling shows
  assign core_level = res_ff ? lvl : ~lvl;
  assign core_tune_a = res_ff ? ta : ~ta;
  assign core_tune_b = res_ff ? tb_v : ~tb_v;
endmodule
`default_nettype wire

// file: tb/ldr_regs_tb_top.sv
// self-checking bench of the lighting director register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module ldr_regs_tb_top;
  import ldr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, crv, cld, conv_start, learn_active, irq;
  logic pready, pslverr, rde;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] clvl, cta, ctb, lux_t, cct_t, lvl, ta, tbv, st, v;
  logic [3:0] chcfg;
  logic [2:0] dly;
  int bad_count, samples_checked;
  int cyc = 0;
  ldr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_result_valid(crv), .core_level(clvl), .core_tune_a(cta),
    .core_tune_b(ctb), .core_learn_done(cld), .conv_start(conv_start),
    .learn_active(learn_active), .channel_configuration(chcfg), .lux_target(lux_t),
    .cct_target(cct_t), .irq(irq));
  ldr_core_model u_core (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .learn_active(learn_active), .dly(dly), .lvl(lvl), .ta(ta), .tb_v(tbv), .res_ff(crv),
    .learn_ff(cld), .core_level(clvl), .core_tune_a(cta), .core_tune_b(ctb));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_ch(input int m, input int c);
    if (c == 1) return lvl;
    if (m == 1) return c == 2 ? ta : ~ta;
    return m == 2 ? tbv : 16'h0000;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata; rde = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d); apb(1'b1, {i, 2'h0}, d); endtask
  task automatic rd(input logic [9:0] i); apb(1'b0, {i, 2'h0}, 8'h00); endtask
  task final_report;
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin bad_count++; final_report; end
  end
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0; st = 16'h002A;
    lvl = 0; ta = 0; tbv = 0; dly = 0; bad_count = 0; samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      rd(i < 8 ? 10'(IDX_DIRECTOR_CONFIG + i) : 10'(IDX_LUX_HIGH + i - 8));
      `CHK({rde, rdv}, 33'h0)
    end
    wr(IDX_CH1_HIGH, 8'hFF); rd(IDX_CH1_HIGH);
    `CHK({rde, rdv}, 33'h0)
    apb(1'b0, 12'h185, 8'h00); `CHK(rde, 1'b1)
    apb(1'b0, 12'h3FC, 8'h00); `CHK(rde, 1'b1)
    for (int k = 0; k < 2; k++) begin
      st = lfsr(st); v = k ? 16'hFFFF : st;
      wr(IDX_LUX_HIGH, v[15:8]); wr(IDX_LUX_LOW, v[7:0]);
      wr(IDX_CCT_HIGH, ~v[15:8]); wr(IDX_CCT_LOW, ~v[7:0]);
      `CHK({lux_t, cct_t}, {v, ~v})
      rd(IDX_LUX_HIGH); `CHK(rdv[7:0], v[15:8])
      rd(IDX_CCT_LOW); `CHK(rdv[7:0], ~v[7:0])
    end
    wr(IDX_IRQ_MASK, 8'h03);
    for (int m = 0; m < 3; m++) begin
      st = lfsr(st); lvl <= st; st = lfsr(st); ta <= st; st = lfsr(st); tbv <= st; dly <= st[2:0];
      wr(IDX_DIRECTOR_CONFIG, {m[3:0], 2'h0, m != 0, 1'b0});
      `CHK(chcfg, m[3:0])
      wr(IDX_DIRECTOR_CONTROL, 8'h01);
      `CHK(conv_start, 1'b1)
      for (int n = 0; n < 40 && conv_start !== 1'b0; n++) @(posedge pclk);
      `CHK({conv_start, irq}, {1'b0, m != 0})
      for (int c = 1; c < 4; c++) begin
        rd(10'(IDX_CH1_HIGH + 2 * c - 2)); v[15:8] = rdv[7:0]; rd(10'(IDX_CH1_LOW + 2 * c - 2));
        `CHK({v[15:8], rdv[7:0]}, exp_ch(m, c))
      end
      rd(IDX_IRQ_STATUS); `CHK(rdv[0], 1'b1)
      wr(IDX_IRQ_STATUS, 8'h01); `CHK(irq, 1'b0)
    end
    wr(IDX_DIRECTOR_CONFIG, 8'h23); `CHK(learn_active, 1'b1)
    for (int n = 0; n < 40 && learn_active !== 1'b0; n++) @(posedge pclk);
    `CHK({learn_active, irq}, 2'b01)
    rd(IDX_DIRECTOR_CONFIG); `CHK(rdv, 32'h00000022)
    final_report;
  end
endmodule
bind ldr_regs ldr_regs_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_result_valid(core_result_valid),
  .core_learn_done(core_learn_done), .conv_start(conv_start), .learn_active(learn_active),
  .channel_configuration(channel_configuration), .lux_target(lux_target), .irq(irq));
`default_nettype wire
